//--- rtl/bcrm_field_writer.sv
module bcrm_field_writer (
    input wire logic clk, // controller clock
    input wire logic reset, // synchronous, active high
    input wire logic start, // one-cycle request to store a field
    input wire logic [7:0] base, // byte address of the field
    input wire logic [31:0] int_part, // integer part, two's complement
    input wire logic [15:0] frac_part, // fractional part
    output logic busy, // high while bytes are going out
    output logic wr_en, // byte write strobe
    output logic [7:0] wr_addr, // byte write address
    output logic [7:0] wr_data // byte write data
);

    // ----------------------------------------------------------------
    // byte serialiser
    // ----------------------------------------------------------------
    logic [47:0] shift_reg;
    logic [7:0] addr_reg;
    logic [2:0] count_reg;

    // most significant byte first at the lowest address
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            count_reg <= 3'd0;
            shift_reg <= 48'h0000_0000_0000;
            addr_reg <= 8'h00;
        end
        else if (start && count_reg == 3'd0)
        begin
            count_reg <= 3'(bcrm_pkg::FIELD_BYTES);
            shift_reg <= {int_part, frac_part};
            addr_reg <= base;
        end
        else if (count_reg != 3'd0)
        begin
            count_reg <= count_reg - 3'd1;
            shift_reg <= {shift_reg[39:0], 8'h00};
            addr_reg <= addr_reg + 8'h01;
        end
    end

    // write port is combinational off the registered shifter
    assign busy = (count_reg != 3'd0);
    assign wr_en = busy;
    assign wr_addr = addr_reg;
    assign wr_data = shift_reg[47:40];

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_field_msb_first: assert property (@(posedge clk) disable iff (reset)
        (start && !busy) |=> (wr_data == $past(int_part[31:24]) && wr_addr == $past(base)))
        else $error("field does not start with its most significant byte");
    chk_field_six_bytes: assert property (@(posedge clk) disable iff (reset)
        (start && !busy) |=> busy [*6] ##1 !busy)
        else $error("field is not six bytes long");

endmodule

//--- rtl/bcrm_mailbox.sv
module bcrm_mailbox #(
    parameter bit EIGHT_AXIS = 1'b1 // response layout: eight-axis or four-axis
) (
    input wire logic clk, // controller clock, 250 MHz
    input wire logic reset, // synchronous, active high
    input wire logic [7:0] bus_addr, // host byte address
    input wire logic [7:0] bus_wdata, // host write data
    input wire logic bus_we, // host write strobe
    input wire logic bus_re, // host read strobe
    output logic [7:0] bus_rdata, // read data, cycle after the strobe
    output logic irq, // level interrupt to the host
    output logic cmd_start, // one-cycle pulse: command handed to the core
    output logic [7:0] cmd_code, // captured command code
    output logic cmd_binary, // command is a binary record
    output logic cmd_interrogate, // command asks for a response
    output logic cmd_group, // coordinated group selected
    output logic [7:0] cmd_axis_mask, // axes with valid data
    input wire logic [5:0] core_rd_addr, // record byte offset from 040
    output logic [7:0] core_rd_data, // record byte, one cycle later
    input wire logic field_valid, // core offers one response field
    output logic field_ready, // field taken this cycle
    input wire logic [2:0] field_axis, // axis of the offered field
    input wire logic [31:0] field_int, // integer part
    input wire logic [15:0] field_frac, // fraction part
    input wire logic core_done, // one-cycle pulse: command finished
    input wire logic core_reject, // with core_done: command refused
    input wire logic core_has_resp // with core_done: response present
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    bcrm_pkg::bcrm_state_e state_reg;
    logic [7:0] mem [0:255];
    logic [7:0] cmd_sem_reg;
    logic [7:0] resp_sem_reg;
    logic [7:0] gen_status_reg;
    logic [2:0] irq_status_reg;
    logic [2:0] irq_mask_reg;
    logic [7:0] resp_mask_reg;
    logic reject_reg;
    logic has_resp_reg;
    logic cmd_start_reg;
    logic [7:0] code_reg;
    logic [7:0] format_reg;
    logic [7:0] group_reg;
    logic [7:0] mask_reg;
    logic wr_busy;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic field_take;
    logic host_cmd_go;
    logic dev_we;
    logic [7:0] dev_addr;
    logic [7:0] dev_data;

    // field base address of an axis for the chosen layout
    function automatic logic [7:0] field_base(input logic [2:0] axis);
        logic [7:0] first;
        first = EIGHT_AXIS ? bcrm_pkg::R8_FIELD0_OFS : bcrm_pkg::R4_FIELD0_OFS;
        return first + 8'(axis * bcrm_pkg::FIELD_BYTES);
    endfunction

    // address lies inside a byte range
    function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    // host setting the busy bit is the hand-over of a command
    assign host_cmd_go = bus_we && bus_addr == bcrm_pkg::CMD_SEM_OFS && bus_wdata[bcrm_pkg::SEM_BUSY_BIT];
    // fields only accepted while the command runs; four-axis drops axes above 3
    assign field_ready = (state_reg == bcrm_pkg::S_EXEC) && !wr_busy;
    assign field_take = field_valid && field_ready && (EIGHT_AXIS || !field_axis[2]);

    // ----------------------------------------------------------------
    // command sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_reg <= bcrm_pkg::S_IDLE;
            cmd_start_reg <= 1'b0;
            reject_reg <= 1'b0;
            has_resp_reg <= 1'b0;
        end
        else
        begin
            cmd_start_reg <= 1'b0;
            unique case (state_reg)
                bcrm_pkg::S_IDLE:
                    if (cmd_sem_reg[bcrm_pkg::SEM_BUSY_BIT])
                    begin
                        // binary code below the lowest number is refused at once
                        if (code_reg[bcrm_pkg::CODE_BINARY_BIT] && code_reg < bcrm_pkg::BIN_CODE_MIN)
                        begin
                            reject_reg <= 1'b1;
                            has_resp_reg <= 1'b0;
                            state_reg <= bcrm_pkg::S_FINISH;
                        end
                        else
                        begin
                            cmd_start_reg <= 1'b1;
                            state_reg <= bcrm_pkg::S_EXEC;
                        end
                    end
                bcrm_pkg::S_EXEC:
                    if (core_done)
                    begin
                        reject_reg <= core_reject;
                        // text or binary, the answer is a binary record
                        has_resp_reg <= core_has_resp && !core_reject;
                        state_reg <= bcrm_pkg::S_DRAIN;
                    end
                bcrm_pkg::S_DRAIN:
                    if (!wr_busy)
                        state_reg <= has_resp_reg ? bcrm_pkg::S_CODE : bcrm_pkg::S_FINISH;
                bcrm_pkg::S_CODE:
                    state_reg <= bcrm_pkg::S_FMT;
                bcrm_pkg::S_FMT:
                    state_reg <= EIGHT_AXIS ? bcrm_pkg::S_MASK : bcrm_pkg::S_FINISH;
                bcrm_pkg::S_MASK:
                    state_reg <= bcrm_pkg::S_FINISH;
                bcrm_pkg::S_FINISH:
                begin
                    reject_reg <= 1'b0;
                    state_reg <= bcrm_pkg::S_IDLE;
                end
                default:
                    state_reg <= bcrm_pkg::S_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // command capture toward the core
    // ----------------------------------------------------------------
    // snapshot the header so host writes during execution cannot skew it
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            code_reg <= bcrm_pkg::RESET_BYTE;
            format_reg <= bcrm_pkg::RESET_BYTE;
            group_reg <= bcrm_pkg::RESET_BYTE;
            mask_reg <= bcrm_pkg::RESET_BYTE;
        end
        else if (state_reg == bcrm_pkg::S_IDLE)
        begin
            code_reg <= mem[bcrm_pkg::CMD_CODE_OFS];
            format_reg <= mem[bcrm_pkg::CMD_FORMAT_OFS];
            group_reg <= mem[bcrm_pkg::CMD_GROUP_OFS];
            mask_reg <= mem[bcrm_pkg::CMD_MASK_OFS];
        end
    end

    assign cmd_start = cmd_start_reg;
    assign cmd_code = code_reg;
    assign cmd_binary = code_reg[bcrm_pkg::CODE_BINARY_BIT];
    assign cmd_interrogate = format_reg[bcrm_pkg::FMT_INTERROGATE_BIT];
    // four-axis layout keeps group and mask in the format byte
    assign cmd_group = EIGHT_AXIS ? group_reg[0] : format_reg[bcrm_pkg::FMT4_GROUP_BIT];
    assign cmd_axis_mask = EIGHT_AXIS ? mask_reg : {4'h0, format_reg[3:0]};

    // core reads the raw record, fields included
    always_ff @(posedge clk)
    begin
        if (reset)
            core_rd_data <= bcrm_pkg::RESET_BYTE;
        else
            core_rd_data <= mem[bcrm_pkg::CMD_CODE_OFS + {2'b00, core_rd_addr}];
    end

    // ----------------------------------------------------------------
    // response record assembly
    // ----------------------------------------------------------------
    bcrm_field_writer u_writer (
        .clk(clk),
        .reset(reset),
        .start(field_take),
        .base(field_base(field_axis)),
        .int_part(field_int),
        .frac_part(field_frac),
        .busy(wr_busy),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data)
    );

    // valid-field mask builds up per command
    always_ff @(posedge clk)
    begin
        if (reset || cmd_start_reg)
            resp_mask_reg <= bcrm_pkg::RESET_BYTE;
        else if (field_take)
            resp_mask_reg <= resp_mask_reg | (8'h01 << field_axis);
    end

    // header bytes go in after the fields; the code byte echoes the command
    always_comb
    begin
        dev_we = wr_en;
        dev_addr = wr_addr;
        dev_data = wr_data;
        unique case (state_reg)
            bcrm_pkg::S_CODE:
            begin
                dev_we = 1'b1;
                dev_addr = EIGHT_AXIS ? bcrm_pkg::R8_CODE_OFS : bcrm_pkg::R4_CODE_OFS;
                dev_data = code_reg;
            end
            bcrm_pkg::S_FMT:
            begin
                dev_we = 1'b1;
                dev_addr = EIGHT_AXIS ? bcrm_pkg::R8_FORMAT_OFS : bcrm_pkg::R4_FORMAT_OFS;
                // four-axis format carries the mask in its low nibble
                dev_data = EIGHT_AXIS ? bcrm_pkg::FMT_RESP_VAL : (bcrm_pkg::FMT_RESP_VAL | {4'h0, resp_mask_reg[3:0]});
            end
            bcrm_pkg::S_MASK:
            begin
                dev_we = 1'b1;
                dev_addr = bcrm_pkg::R8_MASK_OFS;
                dev_data = resp_mask_reg;
            end
            default:
            begin
            end
        endcase
    end

    // device writes win; host may only touch the command record
    always_ff @(posedge clk)
    begin
        if (dev_we)
            mem[dev_addr] <= dev_data;
        else if (bus_we && in_range(bus_addr, bcrm_pkg::CMD_CODE_OFS, bcrm_pkg::CMD_LAST_OFS))
            mem[bus_addr] <= bus_wdata;
    end

    // ----------------------------------------------------------------
    // semaphores and general status
    // ----------------------------------------------------------------
    // host may only set the command semaphore; the device alone clears it
    always_ff @(posedge clk)
    begin
        if (reset)
            cmd_sem_reg <= bcrm_pkg::RESET_BYTE;
        else if (state_reg == bcrm_pkg::S_FINISH)
            cmd_sem_reg <= bcrm_pkg::RESET_BYTE;
        else if (host_cmd_go && state_reg == bcrm_pkg::S_IDLE)
            cmd_sem_reg <= bcrm_pkg::SEM_SET_VAL;
    end

    // response semaphore set as the command ends, so it is valid when done shows
    // a host clear in the same cycle loses to the set
    always_ff @(posedge clk)
    begin
        if (reset)
            resp_sem_reg <= bcrm_pkg::RESET_BYTE;
        else if (state_reg == bcrm_pkg::S_FINISH && has_resp_reg)
            resp_sem_reg <= bcrm_pkg::SEM_SET_VAL;
        else if (bus_we && bus_addr == bcrm_pkg::RESP_SEM_OFS)
            resp_sem_reg <= bus_wdata;
    end

    // reject bit refreshed with every completion
    always_ff @(posedge clk)
    begin
        if (reset)
            gen_status_reg <= bcrm_pkg::RESET_BYTE;
        else if (state_reg == bcrm_pkg::S_FINISH)
            gen_status_reg[bcrm_pkg::GEN_REJECT_BIT] <= reject_reg;
    end

    // ----------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------
    localparam logic [2:0] IRQ_RESET_W = bcrm_pkg::IRQ_RESET;
    logic [2:0] irq_events;
    assign irq_events = {reject_reg, has_resp_reg, 1'b1} & {3{state_reg == bcrm_pkg::S_FINISH}};

    // sticky bits; a read clears them but a new event in that cycle stays
    always_ff @(posedge clk)
    begin
        if (reset)
            irq_status_reg <= IRQ_RESET_W;
        else if (bus_re && bus_addr == bcrm_pkg::IRQ_STATUS_OFS)
            irq_status_reg <= irq_events;
        else
            irq_status_reg <= irq_status_reg | irq_events;
    end

    // mask bits are software owned
    always_ff @(posedge clk)
    begin
        if (reset)
            irq_mask_reg <= IRQ_RESET_W;
        else if (bus_we && bus_addr == bcrm_pkg::IRQ_MASK_OFS)
            irq_mask_reg <= bus_wdata[2:0];
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // ----------------------------------------------------------------
    // host read port
    // ----------------------------------------------------------------
    // unmapped bytes read as zero rather than stale memory
    always_ff @(posedge clk)
    begin
        if (reset)
            bus_rdata <= bcrm_pkg::RESET_BYTE;
        else if (bus_re)
        begin
            if (bus_addr == bcrm_pkg::CMD_SEM_OFS)
                bus_rdata <= cmd_sem_reg;
            else if (bus_addr == bcrm_pkg::RESP_SEM_OFS)
                bus_rdata <= resp_sem_reg;
            else if (bus_addr == bcrm_pkg::GEN_STATUS_OFS)
                bus_rdata <= gen_status_reg;
            else if (bus_addr == bcrm_pkg::IRQ_STATUS_OFS)
                bus_rdata <= {5'h00, irq_status_reg};
            else if (bus_addr == bcrm_pkg::IRQ_MASK_OFS)
                bus_rdata <= {5'h00, irq_mask_reg};
            else if (in_range(bus_addr, bcrm_pkg::CMD_CODE_OFS, bcrm_pkg::CMD_LAST_OFS))
                bus_rdata <= mem[bus_addr];
            else if (EIGHT_AXIS && in_range(bus_addr, bcrm_pkg::R8_CODE_OFS, bcrm_pkg::R8_LAST_OFS))
                bus_rdata <= mem[bus_addr];
            else if (!EIGHT_AXIS && in_range(bus_addr, bcrm_pkg::R4_CODE_OFS, bcrm_pkg::R4_LAST_OFS))
                bus_rdata <= mem[bus_addr];
            else
                bus_rdata <= bcrm_pkg::RESET_BYTE;
        end
        else
            bus_rdata <= bcrm_pkg::RESET_BYTE;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_resp_before_done: assert property (@(posedge clk) disable iff (reset)
        ($fell(cmd_sem_reg[7]) && $past(has_resp_reg)) |-> resp_sem_reg[7])
        else $error("command done shown before response semaphore");
    chk_reject_on_done: assert property (@(posedge clk) disable iff (reset)
        $fell(cmd_sem_reg[7]) |-> gen_status_reg[0] == $past(reject_reg))
        else $error("general status reject bit wrong at completion");
    chk_code_range: assert property (@(posedge clk) disable iff (reset)
        (cmd_start && cmd_binary) |-> cmd_code >= 8'h8A)
        else $error("binary code below range handed to core");
    chk_format_bit7: assert property (@(posedge clk) disable iff (reset)
        (state_reg == bcrm_pkg::S_FMT) |-> dev_we && dev_data[7])
        else $error("response format byte lacks bit 7");
    chk_code_echo: assert property (@(posedge clk) disable iff (reset)
        (state_reg == bcrm_pkg::S_CODE) |=> mem[EIGHT_AXIS ? 8'h90 : 8'h70] == cmd_code)
        else $error("response does not echo the command code");
    chk_resp_sem_set: assert property (@(posedge clk) disable iff (reset)
        (state_reg == bcrm_pkg::S_DRAIN && !wr_busy && has_resp_reg) |-> ##[4:5] resp_sem_reg == 8'h80)
        else $error("response semaphore not set after response");
    chk_host_clear: assert property (@(posedge clk) disable iff (reset)
        (bus_we && bus_addr == 8'h03 && bus_wdata == 8'h00 && state_reg != bcrm_pkg::S_FINISH)
        |=> resp_sem_reg == 8'h00)
        else $error("host clear of response semaphore lost");
    chk_start_on_sem: assert property (@(posedge clk) disable iff (reset)
        (state_reg == bcrm_pkg::S_IDLE && host_cmd_go) |=> ##1 (cmd_start || state_reg == bcrm_pkg::S_FINISH))
        else $error("command semaphore set but command not started");

    cov_interrogation: cover property (@(posedge clk) disable iff (reset)
        $rose(resp_sem_reg[7]));
    cov_rejected: cover property (@(posedge clk) disable iff (reset)
        $rose(gen_status_reg[0]));
    cov_field_stall: cover property (@(posedge clk) disable iff (reset)
        field_valid && !field_ready && state_reg == bcrm_pkg::S_EXEC);

endmodule

//--- rtl/bcrm_pkg.sv
package bcrm_pkg;

    // ----------------------------------------------------------------
    // shared window offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_SEM_OFS = 8'h01;
    localparam logic [7:0] RESP_SEM_OFS = 8'h03;
    localparam logic [7:0] GEN_STATUS_OFS = 8'h10;
    localparam logic [7:0] CMD_CODE_OFS = 8'h40;
    localparam logic [7:0] CMD_FORMAT_OFS = 8'h41;
    localparam logic [7:0] CMD_GROUP_OFS = 8'h42;
    localparam logic [7:0] CMD_MASK_OFS = 8'h43;
    localparam logic [7:0] CMD_LAST_OFS = 8'h73;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'hF0;
    localparam logic [7:0] IRQ_MASK_OFS = 8'hF1;

    // four-axis response record
    localparam logic [7:0] R4_CODE_OFS = 8'h70;
    localparam logic [7:0] R4_FORMAT_OFS = 8'h71;
    localparam logic [7:0] R4_FIELD0_OFS = 8'h72;
    localparam logic [7:0] R4_LAST_OFS = 8'h9F;
    // eight-axis response record
    localparam logic [7:0] R8_CODE_OFS = 8'h90;
    localparam logic [7:0] R8_FORMAT_OFS = 8'h91;
    localparam logic [7:0] R8_MASK_OFS = 8'h93;
    localparam logic [7:0] R8_FIELD0_OFS = 8'h94;
    localparam logic [7:0] R8_LAST_OFS = 8'hC3;

    // ----------------------------------------------------------------
    // field layout and values
    // ----------------------------------------------------------------
    localparam int FIELD_BYTES = 6;
    localparam int INT_BYTES = 4;
    localparam int FRAC_BYTES = 2;
    localparam int SEM_BUSY_BIT = 7;
    localparam int FMT_INTERROGATE_BIT = 7;
    localparam int FMT4_GROUP_BIT = 4;
    localparam int CODE_BINARY_BIT = 7;
    localparam int GEN_REJECT_BIT = 0;
    localparam logic [7:0] SEM_SET_VAL = 8'h80;
    localparam logic [7:0] FMT_RESP_VAL = 8'h80;
    localparam logic [7:0] BIN_CODE_MIN = 8'h8A;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_RESP_BIT = 1;
    localparam int IRQ_REJECT_BIT = 2;

    typedef enum logic [2:0] {S_IDLE, S_EXEC, S_DRAIN, S_CODE, S_FMT, S_MASK, S_FINISH} bcrm_state_e;

endpackage

//--- verification/bcrm_core_model.sv
// stand-in for the motion core: answers every handed-over command
module bcrm_core_model (
    input wire logic clk, // controller clock
    input wire logic cmd_start, // command handed over
    input wire logic cmd_interrogate, // response wanted
    input wire logic [7:0] cmd_axis_mask, // axes to answer
    input wire logic [31:0] base_val, // integer part of axis 0
    input wire logic field_ready, // field taken
    output logic field_valid = 1'b0, // field offered
    output logic [2:0] field_axis = 3'h0, // axis of field
    output logic [31:0] field_int = 32'h0000_0000, // integer part
    output logic [15:0] field_frac = 16'h0000, // fraction part
    output logic core_done = 1'b0, // completion pulse
    output logic core_reject = 1'b0, // never refuses
    output logic core_has_resp = 1'b0 // response present
);
    timeunit 1ns;
    timeprecision 1ps;
    // offer each masked axis in order, holding until taken
    initial
    forever
    begin
        @(posedge clk);
        if (cmd_start)
        begin
            for (int i = 0; i < 8; i++)
                if (cmd_axis_mask[i])
                begin
                    field_valid <= 1'b1;
                    field_axis <= i[2:0];
                    field_int <= base_val + 32'(i);
                    field_frac <= {13'h0000, i[2:0]};
                    @(posedge clk);
                    while (field_ready !== 1'b1)
                        @(posedge clk);
                    field_valid <= 1'b0;
                    @(posedge clk);
                end
            core_done <= 1'b1;
            core_has_resp <= cmd_interrogate;
            @(posedge clk);
            core_done <= 1'b0;
        end
    end
endmodule

//--- verification/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, reset = 1, bus_we = 0, bus_re = 0, re_d = 0;
    logic [7:0] bus_addr = 8'h00, bus_wdata = 8'h00, bus_rdata, cmd_code, cmd_axis_mask, core_rd_data, code, mask;
    logic [7:0] rdata4, mask4;
    logic [5:0] core_rd_addr = 6'h00;
    logic irq, cmd_start, cmd_binary, cmd_interrogate, cmd_group, field_valid, field_ready, irq4, grp4;
    logic core_done, core_reject, core_has_resp, rej, resp;
    logic [2:0] field_axis;
    logic [15:0] field_frac;
    logic [31:0] field_int, base_val = 32'h0000_0000, rnd = 32'h0000_0029;
    logic [47:0] w;
    logic [31:0] exp_q[$];
    logic [7:0] codes[4] = '{8'h8A, 8'h00, 8'h53, 8'h89};
    logic [7:0] fmts[4] = '{8'h80, 8'h00, 8'hD4, 8'h80};
    int err_total = 0, tests_run = 0, cyc = 0, starts = 0;
    bcrm_mailbox DUT (.*);
    // four-axis copy on the same bus and core, so the other response layout is exercised too
    bcrm_mailbox #(.EIGHT_AXIS(1'b0)) DUT4 (.clk(clk), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_we(bus_we), .bus_re(bus_re), .bus_rdata(rdata4), .irq(irq4), .cmd_start(), .cmd_code(), .cmd_binary(),
        .cmd_interrogate(), .cmd_group(grp4), .cmd_axis_mask(mask4), .core_rd_addr(core_rd_addr), .core_rd_data(),
        .field_valid(field_valid), .field_ready(), .field_axis(field_axis), .field_int(field_int),
        .field_frac(field_frac), .core_done(core_done), .core_reject(core_reject), .core_has_resp(core_has_resp));
    bcrm_core_model core (.*);
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        tests_run++;
        if (seen !== expd)
        begin
            err_total++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, expd);
        end
    endtask
    task automatic tally_and_finish();
        if (err_total == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_we <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_we <= 1'b0;
        @(posedge clk);
    endtask
    // the note carries a care mask above the expected byte
    // the four-axis copy's note rides in the upper half; a zero care mask skips it
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m, input logic [7:0] e4 = 8'h00,
        input logic [7:0] m4 = 8'h00);
        exp_q.push_back({m4, e4, m, e});
        bus_re <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_re <= 1'b0;
        @(posedge clk);
    endtask
    // ----------------------------------------------------------------
    // clock, watchdog and read-data monitor
    // ----------------------------------------------------------------
    initial
    forever
        #2 clk = ~clk;
    // read data stand only in the cycle after the strobe
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 8000)
        begin
            err_total++;
            tally_and_finish();
        end
        if (re_d)
        begin
            check(bus_rdata & exp_q[0][15:8], exp_q[0][7:0] & exp_q[0][15:8]);
            if (exp_q[0][31:24] != 8'h00)
                check(rdata4 & exp_q[0][31:24], exp_q[0][23:16] & exp_q[0][31:24]);
            void'(exp_q.pop_front());
        end
        if (cmd_start)
            starts <= starts + 1;
        re_d <= bus_re;
    end
    // four commands: lowest binary code, random code, text, refused code
    initial
    begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        wr(bcrm_pkg::IRQ_MASK_OFS, 8'h07);
        rd(8'hE0, 8'h00, 8'hFF);
        for (int k = 0; k < 4; k++)
        begin
            rnd = xs(rnd);
            base_val <= rnd;
            core_rd_addr <= 6'(k);
            code = (k == 1) ? (rnd[15:8] | 8'h90) : codes[k];
            mask = rnd[23:16] | 8'h01;
            rej = (code == 8'h89);
            resp = fmts[k][7] && !rej;
            wr(8'h40, code);
            wr(8'h41, fmts[k]);
            wr(8'h42, {7'h00, rnd[24]});
            wr(8'h43, mask);
            wr(bcrm_pkg::CMD_SEM_OFS, bcrm_pkg::SEM_SET_VAL);
            for (int n = 0; n < 300 && irq !== 1'b1; n++)
                @(posedge clk);
            #1;
            check(irq, 1'b1);
            check(cmd_group, rnd[24]);
            check(cmd_axis_mask, mask);
            check(cmd_interrogate, fmts[k][7]);
            check(cmd_binary, code[7]);
            check(cmd_code, code);
            check(core_rd_data, k == 0 ? code : k == 1 ? fmts[k] : k == 2 ? {7'h00, rnd[24]} : mask);
            check(irq4, 1'b1);
            check(grp4, fmts[k][4]);
            check(mask4, {4'h0, fmts[k][3:0]});
            rd(bcrm_pkg::CMD_SEM_OFS, 8'h00, 8'h80);
            rd(bcrm_pkg::GEN_STATUS_OFS, {7'h00, rej}, 8'h01, {7'h00, rej}, 8'h01);
            rd(bcrm_pkg::RESP_SEM_OFS, resp ? 8'h80 : 8'h00, 8'hFF, resp ? 8'h80 : 8'h00, 8'hFF);
            if (resp)
            begin
                rd(8'h90, code, 8'hFF);
                rd(8'h91, 8'h80, 8'hFF);
                rd(8'h93, mask, 8'hFF);
                rd(8'h70, 8'h00, 8'h00, code, 8'hFF);
                rd(8'h71, 8'h00, 8'h00, 8'h80 | {4'h0, mask[3:0]}, 8'hFF);
                for (int a = 0; a < 8; a++)
                    for (int b = 0; b < 6 && mask[a]; b++)
                    begin
                        w = {rnd + 32'(a), 13'h0000, 3'(a)};
                        rd(8'h94 + 8'(6 * a + b), w[47 - 8 * b -: 8], 8'hFF);
                        if (a < 4)
                            rd(8'h72 + 8'(6 * a + b), 8'h00, 8'h00, w[47 - 8 * b -: 8], 8'hFF);
                    end
            end
            rd(8'hF0, {5'h00, rej, resp, 1'b1}, 8'hFF, {5'h00, rej, resp, 1'b1}, 8'hFF);
            #1;
            check(irq, 1'b0);
            check(irq4, 1'b0);
            wr(bcrm_pkg::RESP_SEM_OFS, 8'h00);
            rd(bcrm_pkg::RESP_SEM_OFS, 8'h00, 8'hFF, 8'h00, 8'hFF);
        end
        // the refused code must never reach the core
        check(starts, 3);
        tally_and_finish();
    end
endmodule
